/* hdl/smc_mute_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_mute_controller #(
	parameter int DISCORD_CYCLES = smc_pkg::DISCORD_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic muteEnable,
	input wire logic [1:0] chanPresent,
	input wire logic [1:0] safetyInA,
	input wire logic [1:0] safetyInB,
	input wire logic [2:0] sensorCount1,
	input wire logic [2:0] sensorCount2,
	input wire logic chan1DarkSensorA,
	input wire logic chan1LightSensorB,
	input wire logic chan1DarkSensorC,
	input wire logic chan1LightSensorD,
	input wire logic chan2DarkSensorA,
	input wire logic chan2LightSensorB,
	input wire logic chan2DarkSensorC,
	input wire logic chan2LightSensorD,
	input wire logic [1:0] lampCurrentOk,
	output logic [1:0] safetySwitchingOutput,
	output logic [1:0] muteLamp,
	output logic muteActive,
	output logic muteArmed,
	output logic lockout,
	output logic [7:0] diagCode,
	output logic [3:0] ledSafetyIn,
	output logic [7:0] ledSensor,
	output logic [1:0] ledLamp,
	output logic ledOutput
);

	// ==========================================================
	// State
	typedef struct packed {
		smc_pkg::smc_state_t [smc_pkg::NUM_CH-1:0] st;
		logic [smc_pkg::NUM_CH-1:0][smc_pkg::STEP_W-1:0] step;
		logic [smc_pkg::NUM_CH-1:0][smc_pkg::LAMP_W-1:0] lampCnt;
		logic [smc_pkg::NUM_CH-1:0][smc_pkg::DISC_W-1:0] discCnt;
		logic [smc_pkg::NUM_CH-1:0] lampFault;
		logic [smc_pkg::NUM_CH-1:0] seqErr;
		logic [smc_pkg::NUM_CH-1:0] discFault;
		logic [smc_pkg::NUM_CH-1:0] lamp;
		logic [smc_pkg::NUM_CH-1:0] lampOffPrev;
		logic lampLock;
		logic startDone;
		logic safety_switching_output;
		logic armed;
		logic [7:0] diag;
		logic [3:0] ledSafe;
		logic [7:0] ledSens;
	} smc_regs_t;

	smc_regs_t r;
	smc_regs_t next_r;

	localparam logic [smc_pkg::DISC_W-1:0] DISC_LAST = smc_pkg::DISC_W'(DISCORD_CYCLES - 1);
	localparam logic [smc_pkg::LAMP_W-1:0] LAMP_LAST = smc_pkg::LAMP_W'(smc_pkg::LAMP_CYC - 1);
	localparam logic [smc_pkg::STEP_W-1:0] MIN_CNT = smc_pkg::STEP_W'(smc_pkg::MIN_SENS);
	localparam logic [smc_pkg::STEP_W-1:0] MAX_CNT = smc_pkg::STEP_W'(smc_pkg::NUM_SENS);

	function automatic logic [3:0] onesMask(input logic [2:0] k);
		onesMask = 4'((5'h01 << k) - 5'h01);
	endfunction : onesMask

	// ==========================================================
	// Input shaping
	logic [1:0][3:0] rdy;
	logic [1:0][2:0] cnt;
	logic [1:0] clear;

	always_comb begin
		// Ready levels per sensor polarity
		// sensor polarity
		rdy[0] = {~chan1LightSensorD, chan1DarkSensorC, ~chan1LightSensorB, chan1DarkSensorA};
		rdy[1] = {~chan2LightSensorD, chan2DarkSensorC, ~chan2LightSensorB, chan2DarkSensorA};
		cnt[0] = sensorCount1;
		cnt[1] = sensorCount2;
		for (int c = 0; c < smc_pkg::NUM_CH; c++) begin
			// Out-of-range counts are pinned into the legal window
			if (cnt[c] < MIN_CNT) begin
				cnt[c] = MIN_CNT;
			end else if (cnt[c] > MAX_CNT) begin
				cnt[c] = MAX_CNT;
			end
			clear[c] = ~chanPresent[c] | (safetyInA[c] & safetyInB[c] & ~r.discFault[c]);
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		logic [3:0] full;
		logic [3:0] seen;
		logic anyLampFault;
		logic allOk;
		next_r = r;
		full = 4'h0;
		seen = 4'h0;
		anyLampFault = |r.lampFault;
		allOk = 1'b1;
		next_r.armed = muteEnable;
		for (int c = 0; c < smc_pkg::NUM_CH; c++) begin
			full = onesMask(cnt[c]);
			seen = rdy[c] & full;
			if (chanPresent[c] && (safetyInA[c] != safetyInB[c])) begin
				if (r.discCnt[c] == DISC_LAST) begin
					next_r.discFault[c] = 1'b1;
				end else begin
					next_r.discCnt[c] = r.discCnt[c] + 1'b1;
				end
			end else begin
				next_r.discCnt[c] = '0;
			end
			if (r.lampOffPrev[c] && !r.lamp[c] && lampCurrentOk[c]) begin
				next_r.lampLock = 1'b1;
			end
			next_r.lampOffPrev[c] = ~r.lamp[c];
			if (!muteEnable || !chanPresent[c]) begin
				// Disabling muting also clears its errors
				next_r.st[c] = smc_pkg::SMC_IDLE;
				next_r.step[c] = '0;
				next_r.lampFault[c] = 1'b0;
				next_r.seqErr[c] = 1'b0;
			end else begin
				case (r.st[c])
					smc_pkg::SMC_IDLE: begin
						next_r.step[c] = '0;
						if (seen == onesMask(3'h1)) begin
							next_r.st[c] = smc_pkg::SMC_SEQ;
							next_r.step[c] = 3'h1;
							next_r.seqErr[c] = 1'b0;
						end else if (seen != 4'h0) begin
							next_r.st[c] = smc_pkg::SMC_WAIT_CLEAR;
							next_r.seqErr[c] = 1'b1;
						end
					end
					smc_pkg::SMC_SEQ: begin
						if (seen == onesMask(r.step[c])) begin
							next_r.st[c] = smc_pkg::SMC_SEQ;
						end else if (seen == onesMask(r.step[c] + 3'h1)) begin
							next_r.step[c] = r.step[c] + 3'h1;
							if ((r.step[c] + 3'h1) == cnt[c] && !anyLampFault) begin
								next_r.st[c] = smc_pkg::SMC_LAMP_CHECK;
								next_r.lampCnt[c] = '0;
							end
						end else if (seen == 4'h0) begin
							next_r.st[c] = smc_pkg::SMC_IDLE;
						end else begin
							next_r.st[c] = smc_pkg::SMC_WAIT_CLEAR;
							next_r.seqErr[c] = 1'b1;
						end
					end
					smc_pkg::SMC_LAMP_CHECK: begin
						if (seen != full) begin
							next_r.st[c] = smc_pkg::SMC_WAIT_CLEAR;
						end else if (lampCurrentOk[c]) begin
							next_r.st[c] = smc_pkg::SMC_MUTED;
						end else if (r.lampCnt[c] == LAMP_LAST) begin
							next_r.lampFault[c] = 1'b1;
							next_r.st[c] = smc_pkg::SMC_WAIT_CLEAR;
						end else begin
							next_r.lampCnt[c] = r.lampCnt[c] + 1'b1;
						end
					end
					smc_pkg::SMC_MUTED: begin
						if (!lampCurrentOk[c]) begin
							next_r.lampFault[c] = 1'b1;
							next_r.st[c] = smc_pkg::SMC_WAIT_CLEAR;
						end else if (seen != full) begin
							next_r.st[c] = smc_pkg::SMC_WAIT_CLEAR;
						end
					end
					smc_pkg::SMC_WAIT_CLEAR: begin
						if (seen == 4'h0) begin
							next_r.st[c] = smc_pkg::SMC_IDLE;
						end
					end
					default: begin
						next_r.st[c] = smc_pkg::SMC_IDLE;
					end
				endcase
			end
			// lamp on while checking or muted
			next_r.lamp[c] = (next_r.st[c] == smc_pkg::SMC_LAMP_CHECK)
				|| (next_r.st[c] == smc_pkg::SMC_MUTED);
			if (!(clear[c] || (next_r.st[c] == smc_pkg::SMC_MUTED))) begin
				allOk = 1'b0;
			end
		end
		if (!r.lampLock && (&clear)) begin
			next_r.startDone = 1'b1;
		end
		// one-cycle response
		// Discordance lockout also stops a muted channel
		next_r.safety_switching_output = next_r.startDone && !next_r.lampLock && !(|next_r.discFault) && allOk;
		// Fault codes in priority order
		if (r.lampLock) begin
			next_r.diag = smc_pkg::DIAG_LAMP_LOCK;
		end else if (|r.discFault) begin
			next_r.diag = smc_pkg::DIAG_DISCORD;
		end else if (|r.lampFault) begin
			next_r.diag = smc_pkg::DIAG_LAMP_FAULT;
		end else if (|r.seqErr) begin
			next_r.diag = smc_pkg::DIAG_SEQ_ERR;
		end else if (|r.lamp) begin
			next_r.diag = smc_pkg::DIAG_MUTED;
		end else if (!r.startDone) begin
			next_r.diag = smc_pkg::DIAG_WAIT_CLEAR;
		end else begin
			next_r.diag = smc_pkg::DIAG_OK;
		end
		next_r.ledSafe = {safetyInB[1], safetyInA[1], safetyInB[0], safetyInA[0]};
		next_r.ledSens = {rdy[1], rdy[0]};
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// Outputs
	assign safetySwitchingOutput = {r.safety_switching_output, r.safety_switching_output};
	assign muteLamp = r.lamp;
	assign muteActive = (r.st[0] == smc_pkg::SMC_MUTED) || (r.st[1] == smc_pkg::SMC_MUTED);
	assign muteArmed = r.armed;
	assign lockout = r.lampLock | (|r.discFault);
	assign diagCode = r.diag;
	assign ledSafetyIn = r.ledSafe;
	assign ledSensor = r.ledSens;
	assign ledLamp = r.lamp;
	assign ledOutput = r.safety_switching_output;

endmodule : smc_mute_controller
`default_nettype wire

/* common/smc_pkg.sv */
// How it works
// - With muting off, the switching outputs follow the safety inputs.
// - Two independent channels, each with two safety signals (A and B) and two to four sensors.
// - The second channel may be absent; an absent channel neither stops nor mutes.
// - Muting starts only when the sensors become ready in order A, B, C, D.
// - The lamp circuit of each channel is watched through its current sense.
// - A fault on any lamp circuit blocks entry into muting.
// - A channel's lamp output is on for the whole time the channel is muted.
// - The switching outputs follow a safety input change well within 1 ms.
// - Safety inputs, sensors, lamp outputs and switching outputs have registered status indicators; both switching outputs share one.
// - Lamp current is needed to mute; current while the lamp output is off causes lockout.
// - Outputs are on when running with clear inputs, or when muted.
// - Sensors A and C are ready when high; B and D when low.
// - Two safety signals disagreeing longer than 300 ms cause a fault.
`default_nettype none
package smc_pkg;
	localparam int NUM_CH = 2;
	localparam int NUM_SENS = 4;
	localparam int MIN_SENS = 2;
	localparam int STEP_W = 3;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESPONSE_NS = 1000000;
	localparam int RESPONSE_CYC = RESPONSE_NS / CLK_PERIOD_NS;
	localparam int DISCORD_MS = 300;
	localparam int DISCORD_CYC = DISCORD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int DISC_W = 25;
	localparam int LAMP_CHECK_NS = 1000;
	localparam int LAMP_CYC = LAMP_CHECK_NS / CLK_PERIOD_NS;
	localparam int LAMP_W = 7;
	localparam logic [7:0] DIAG_OK = 8'h00;
	localparam logic [7:0] DIAG_MUTED = 8'h01;
	localparam logic [7:0] DIAG_WAIT_CLEAR = 8'h02;
	localparam logic [7:0] DIAG_SEQ_ERR = 8'h10;
	localparam logic [7:0] DIAG_LAMP_FAULT = 8'h20;
	localparam logic [7:0] DIAG_DISCORD = 8'h30;
	localparam logic [7:0] DIAG_LAMP_LOCK = 8'h40;
	typedef enum logic [2:0] {
		SMC_IDLE,
		SMC_SEQ,
		SMC_LAMP_CHECK,
		SMC_MUTED,
		SMC_WAIT_CLEAR
	} smc_state_t;
endpackage : smc_pkg
`default_nettype wire

/* test/smc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// Output rule checks
module smc_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic muteEnable,
	input wire logic [1:0] chanPresent,
	input wire logic [1:0] safetyInA,
	input wire logic [1:0] safetySwitchingOutput,
	input wire logic [1:0] muteLamp,
	input wire logic muteActive,
	input wire logic lockout,
	input wire logic [1:0] ledLamp,
	input wire logic ledOutput
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	out_pair_a: assert property (safetySwitchingOutput[0] == safetySwitchingOutput[1])
		else $error("switching bits differ");
	led_out_a: assert property (ledOutput == safetySwitchingOutput[0])
		else $error("output led wrong");
	led_lamp_a: assert property (ledLamp == muteLamp)
		else $error("lamp led wrong");
	mute_lamp_a: assert property (muteActive |-> muteLamp != 2'h0)
		else $error("muted with lamp off");
	enable_off_a: assert property (!muteEnable |=> !muteActive)
		else $error("muted while disabled");
	drop_stop_a: assert property (chanPresent[0] && !safetyInA[0] && !muteEnable
		|=> !safetySwitchingOutput[0]) else $error("no stop on drop");
	lock_stop_a: assert property (lockout |=> !safetySwitchingOutput[0])
		else $error("output on in lockout");
	lock_hold_a: assert property (lockout |=> lockout)
		else $error("lockout released");
	absent_idle_a: assert property (!chanPresent[1] |=> !muteLamp[1])
		else $error("absent channel lamp on");
	mute_c: cover property (muteActive);
	drop_c: cover property (muteActive && !safetyInA[0]);
	lock_c: cover property (lockout);
endmodule : smc_checker
`default_nettype wire

/* test/smc_field_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// Safety devices, sensors, lamps
module smc_field_model (
	input wire logic [1:0] clear,
	input wire logic breakB,
	input wire logic [7:0] ready,
	input wire logic lampGood,
	input wire logic stray,
	input wire logic [1:0] muteLamp,
	output logic [1:0] safetyInA,
	output logic [1:0] safetyInB,
	output logic [7:0] sens,
	output logic [1:0] lampCur
);
	// two clear signals, breakB can drop B of the first channel
	assign safetyInA = clear;
	assign safetyInB = clear & ~{1'b0, breakB};
	assign sens = ready ^ 8'hAA;
	assign lampCur = (muteLamp & {2{lampGood}}) | {2{stray}};
endmodule : smc_field_model
`default_nettype wire

/* test/safety_mute_controller_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module safety_mute_controller_tb_top;
	logic clk, srst, muteEnable, brk, good, stray, mute, armed, lock, ledO;
	logic [1:0] pres, clr, sA, sB, lampCur, safety_switching_output, lamp, ledL;
	logic [7:0] rdy, sens, diag, ledSens;
	logic [3:0] ledIn;
	logic [2:0] cnt1, cnt2;
	int fails, num_checks, cyc;
	always #5 clk = ~clk;
	smc_field_model fm (.clear(clr), .breakB(brk), .ready(rdy), .lampGood(good), .stray(stray),
		.muteLamp(lamp), .safetyInA(sA), .safetyInB(sB), .sens(sens), .lampCur(lampCur));
	smc_mute_controller #(.DISCORD_CYCLES(50)) uut (.clk(clk), .srst(srst),
		.muteEnable(muteEnable), .chanPresent(pres), .safetyInA(sA), .safetyInB(sB),
		.sensorCount1(cnt1), .sensorCount2(cnt2), .chan1DarkSensorA(sens[0]),
		.chan1LightSensorB(sens[1]), .chan1DarkSensorC(sens[2]), .chan1LightSensorD(sens[3]),
		.chan2DarkSensorA(sens[4]), .chan2LightSensorB(sens[5]), .chan2DarkSensorC(sens[6]),
		.chan2LightSensorD(sens[7]), .lampCurrentOk(lampCur), .safetySwitchingOutput(safety_switching_output),
		.muteLamp(lamp), .muteActive(mute), .muteArmed(armed), .lockout(lock),
		.diagCode(diag), .ledSafetyIn(ledIn), .ledSensor(ledSens), .ledLamp(ledL),
		.ledOutput(ledO));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	// Hang guard, run needs well under 1000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			report_and_stop;
		end
	end
	initial begin
		clk = 0; srst = 1; muteEnable = 0; pres = 2'h3; clr = 2'h0; brk = 0;
		rdy = 8'h00; good = 1; stray = 0; fails = 0; num_checks = 0; cyc = 0;
		cnt1 = 3'h2;
		cnt2 = 3'h2;
		void'($urandom(35361));
		wt(11);
		chk({6'h0, safety_switching_output}, 8'h00);
		@(posedge clk) srst <= 0;
		wt(3);
		chk(diag, smc_pkg::DIAG_WAIT_CLEAR);
		@(posedge clk) clr <= 2'h3;
		wt(2);
		chk({6'h0, safety_switching_output}, 8'h03);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk) begin
				clr <= 2'($urandom);
				pres <= 2'($urandom) | 2'h1;
				rdy <= 8'($urandom);
			end
			wt(2);
			chk({6'h0, safety_switching_output}, ((clr | ~pres) == 2'h3) ? 8'h03 : 8'h00);
			chk({4'h0, ledIn}, {4'h0, clr[1], clr[1], clr[0], clr[0]});
			chk(ledSens, rdy);
		end
		@(posedge clk) begin
			clr <= 2'h3;
			pres <= 2'h3;
			muteEnable <= 1;
			rdy <= 8'h01;
		end
		wt(2);
		@(posedge clk) rdy <= 8'h03;
		wt(4);
		chk({5'h0, mute, lamp}, 8'h05);
		chk({7'h0, armed}, 8'h01);
		@(posedge clk) clr <= 2'h2;
		wt(2);
		chk({6'h0, safety_switching_output}, 8'h03);
		@(posedge clk) rdy <= 8'h00;
		wt(3);
		chk({5'h0, mute, safety_switching_output}, 8'h00);
		@(posedge clk) begin
			clr <= 2'h3;
			rdy <= 8'h02;
		end
		wt(2);
		@(posedge clk) rdy <= 8'h03;
		wt(4);
		chk({5'h0, mute, lamp}, 8'h00);
		chk(diag, smc_pkg::DIAG_SEQ_ERR);
		@(posedge clk) begin
			rdy <= 8'h00;
			muteEnable <= 0;
		end
		wt(2);
		@(posedge clk) begin
			muteEnable <= 1;
			good <= 0;
			rdy <= 8'h01;
		end
		wt(2);
		@(posedge clk) rdy <= 8'h03;
		wt(110);
		chk({7'h0, mute}, 8'h00);
		chk(diag, smc_pkg::DIAG_LAMP_FAULT);
		// Other channel blocked by the lamp fault
		@(posedge clk) begin
			good <= 1;
			rdy <= 8'h13;
		end
		@(posedge clk) rdy <= 8'h33;
		wt(4);
		chk({5'h0, mute, lamp}, 8'h00);
		@(posedge clk) clr <= 2'h0;
		wt(2);
		chk({6'h0, safety_switching_output}, 8'h00);
		@(posedge clk) begin
			muteEnable <= 0;
			rdy <= 8'h00;
			good <= 1;
			clr <= 2'h3;
		end
		wt(3);
		@(posedge clk) stray <= 1;
		wt(4);
		chk({5'h0, lock, safety_switching_output}, 8'h04);
		@(posedge clk) begin
			stray <= 0;
			srst <= 1;
		end
		wt(2);
		@(posedge clk) srst <= 0;
		wt(3);
		chk({6'h0, safety_switching_output}, 8'h03);
		// Four sensors on the second channel, back to back
		@(posedge clk) begin
			cnt2 <= 3'h4;
			muteEnable <= 1;
			rdy <= 8'h10;
		end
		@(posedge clk) rdy <= 8'h30;
		@(posedge clk) rdy <= 8'h70;
		@(posedge clk) rdy <= 8'hF0;
		wt(4);
		chk({5'h0, mute, lamp}, 8'h06);
		@(posedge clk) brk <= 1;
		wt(45);
		chk({5'h0, lock, safety_switching_output}, 8'h00);
		wt(15);
		chk({5'h0, lock, safety_switching_output}, 8'h04);
		report_and_stop;
	end
endmodule : safety_mute_controller_tb_top
bind smc_mute_controller smc_checker chk_i (.clk(clk), .srst(srst), .muteEnable(muteEnable),
	.chanPresent(chanPresent), .safetyInA(safetyInA),
	.safetySwitchingOutput(safetySwitchingOutput), .muteLamp(muteLamp),
	.muteActive(muteActive), .lockout(lockout), .ledLamp(ledLamp), .ledOutput(ledOutput));
`default_nettype wire
